// >>> hw/slcd_map.svh
// Register addresses, bit positions and timing constants of the LCD block
`ifndef SLCD_MAP_SVH
`define SLCD_MAP_SVH
`define SLCD_ADDR_CON 8'h95
`define SLCD_ADDR_CLK 8'h96
`define SLCD_ADDR_CONX 8'h9c
`define SLCD_ADDR_PTR 8'hac
`define SLCD_ADDR_DAT 8'hae
`define SLCD_ADDR_CONY 8'hb1
`define SLCD_CON_EN 7
`define SLCD_CON_CLR 6
`define SLCD_CON_BLINK 5
`define SLCD_CON_PSM 4
`define SLCD_CON_LCD_CLOCK_SELECT 3
`define SLCD_CON_BIAS 2
`define SLCD_CON_CLR_MASK 8'hbf
`define SLCD_PTR_WR 7
`define SLCD_PTR_MASK 8'hbf
`define SLCD_CONX_LADDER 6
`define SLCD_CONY_FREEZE 0
`define SLCD_RST_BYTE 8'h00
`define SLCD_MEM_BYTES 15
`define SLCD_MEM_LAST 6'h0e
`define SLCD_CLK_HZ 10000000
`define SLCD_FAST_HZ 2048
`define SLCD_SLOW_HZ 128
`define SLCD_HALF_STEPS 2
`define SLCD_BLINK_BASE 11'h040
`define SLCD_BLINK_TOP 3'h4
`define SLCD_STEP_FD15 7'h01
`define SLCD_STEP_FD0 7'h02
`define SLCD_STEP_FD1 7'h04
`define SLCD_STEP_FD2 7'h06
`define SLCD_STEP_SLOW 7'h08
`endif

// >>> hw/slcd_pkg.sv
// Types shared by the segment LCD controller
package slcd_pkg;
    typedef logic [7:0] slcd_byte_t;
    typedef enum logic [1:0] {
        SLCD_MUX_STATIC = 2'h0,
        SLCD_MUX_TWO = 2'h1,
        SLCD_MUX_FOUR = 2'h3,
        SLCD_MUX_THREE = 2'h2
    } slcd_mux_t;
endpackage

// >>> hw/slcd_ticks.sv
// Base clock dividers producing the two LCD clock enables
`timescale 1ns/1ps
module slcd_ticks #(
    parameter int unsigned FAST_DIV = 2,
    parameter int unsigned SLOW_DIV = 2
) (
    input wire logic clk,        // System clock
    input wire logic rst,        // Async reset, active high
    output logic tick_fast,      // Fast base clock enable
    output logic tick_slow       // Slow base clock enable
);
    localparam int unsigned DIVS [2] = '{FAST_DIV, SLOW_DIV};
    logic [1:0] tick;

    // One free running divider per base rate
    for (genvar i = 0; i < 2; i++) begin : g_div
        logic [16:0] cnt_r;
        wire last = (cnt_r == 17'(DIVS[i] - 1));
        always_ff @(posedge clk or posedge rst) begin
            if (rst)
                cnt_r <= 17'h00000;
            else
                cnt_r <= last ? 17'h00000 : cnt_r + 17'h00001;
        end
        assign tick[i] = last;
    end

    // Enables are single cycle pulses
    assign tick_fast = tick[0];
    assign tick_slow = tick[1];
endmodule

// >>> hw/slcd_ctrl.sv
// Segment LCD controller: registers, data memory, timing and drive
`timescale 1ns/1ps
`include "slcd_map.svh"
module slcd_ctrl #(
    parameter int unsigned FAST_DIV =
        `SLCD_CLK_HZ / (`SLCD_HALF_STEPS * `SLCD_FAST_HZ),
    parameter int unsigned SLOW_DIV =
        `SLCD_CLK_HZ / (`SLCD_HALF_STEPS * `SLCD_SLOW_HZ)
) (
    input wire logic clk,               // System clock, 10 MHz
    input wire logic rst,               // Async reset, active high
    input wire logic [7:0] sfr_addr,    // Register address
    input wire logic [7:0] sfr_wdata,   // Write data
    input wire logic sfr_wr,            // Write strobe
    input wire logic sfr_rd,            // Read strobe
    output logic [7:0] sfr_rdata,       // Read data, one cycle late
    input wire logic rtc_enable,        // RTC peripheral running
    input wire logic deep_power_save_mode, // Chip in deep power save
    output logic [3:0] common_line,     // Common drive levels
    output logic [28:0] segment_line,   // Segment pin levels
    output logic drive_polarity,        // Current inversion phase
    output logic display_on,            // Display visible
    output logic pump_enable,           // Charge pump running
    output logic ladder_select,         // External ladder in use
    output logic [5:0] bias_level,      // Pump bias level
    output logic bias_third             // Bias mode bit
);
    // ************************************************************
    // Register file
    // ************************************************************
    slcd_pkg::slcd_byte_t con_r, clk_ctl_r, conx_r;
    slcd_pkg::slcd_byte_t ptr_r, dat_r, cony_r, rdata_r;
    slcd_pkg::slcd_byte_t mem_r [`SLCD_MEM_BYTES];
    slcd_pkg::slcd_byte_t shadow_r [`SLCD_MEM_BYTES];

    // Address decode
    wire sel_con = (sfr_addr == `SLCD_ADDR_CON);
    wire sel_clk = (sfr_addr == `SLCD_ADDR_CLK);
    wire sel_conx = (sfr_addr == `SLCD_ADDR_CONX);
    wire sel_ptr = (sfr_addr == `SLCD_ADDR_PTR);
    wire sel_dat = (sfr_addr == `SLCD_ADDR_DAT);
    wire sel_cony = (sfr_addr == `SLCD_ADDR_CONY);
    wire wr_ptr = sfr_wr & sel_ptr;
    wire [5:0] wr_idx = sfr_wdata[5:0];
    wire idx_ok = (wr_idx <= `SLCD_MEM_LAST);
    wire ptr_wr_hit = wr_ptr & sfr_wdata[`SLCD_PTR_WR] & idx_ok;
    wire ptr_rd = wr_ptr & ~sfr_wdata[`SLCD_PTR_WR];
    wire mem_clear = sfr_wr & sel_con & sfr_wdata[`SLCD_CON_CLR];
    wire freeze = cony_r[`SLCD_CONY_FREEZE];

    // Memory byte lookup, zero beyond the last byte
    function automatic slcd_pkg::slcd_byte_t mem_read(
        input logic [5:0] a,
        input slcd_pkg::slcd_byte_t m [`SLCD_MEM_BYTES]
    );
        mem_read = (a <= `SLCD_MEM_LAST) ? m[a[3:0]] : `SLCD_RST_BYTE;
    endfunction

    wire slcd_pkg::slcd_byte_t mem_at_wr = mem_read(wr_idx, mem_r);
    wire slcd_pkg::slcd_byte_t mem_at_ptr = mem_read(ptr_r[5:0], mem_r);

    // Plain control registers; clear bit never stored, it acts once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            con_r <= `SLCD_RST_BYTE;
            clk_ctl_r <= `SLCD_RST_BYTE;
            conx_r <= `SLCD_RST_BYTE;
            cony_r <= `SLCD_RST_BYTE;
        end else begin
            if (sfr_wr & sel_con)
                con_r <= sfr_wdata & `SLCD_CON_CLR_MASK;
            if (sfr_wr & sel_clk)
                clk_ctl_r <= sfr_wdata;
            if (sfr_wr & sel_conx)
                conx_r <= sfr_wdata;
            if (sfr_wr & sel_cony)
                cony_r <= sfr_wdata;
        end
    end

    // Pointer and data exchange; a pointer write is the transfer trigger
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_r <= `SLCD_RST_BYTE;
            dat_r <= `SLCD_RST_BYTE;
        end else begin
            if (wr_ptr)
                ptr_r <= sfr_wdata & `SLCD_PTR_MASK;
            if (ptr_rd)
                dat_r <= mem_at_wr;
            else if (sfr_wr & sel_dat)
                dat_r <= sfr_wdata;
        end
    end

    // Readback mux; unmapped addresses read zero
    wire slcd_pkg::slcd_byte_t rd_mux =
        sel_con ? con_r :
        sel_clk ? clk_ctl_r :
        sel_conx ? conx_r :
        sel_ptr ? ptr_r :
        sel_dat ? dat_r :
        sel_cony ? cony_r : `SLCD_RST_BYTE;

    // Read data held until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rdata_r <= `SLCD_RST_BYTE;
        else if (sfr_rd)
            rdata_r <= rd_mux;
    end
    assign sfr_rdata = rdata_r;

    // ************************************************************
    // Segment memory and shadow
    // ************************************************************
    // No power mode input touches these flops, so contents survive it
    for (genvar i = 0; i < `SLCD_MEM_BYTES; i++) begin : g_mem
        wire hit = ptr_wr_hit & (wr_idx == 6'(i));
        always_ff @(posedge clk or posedge rst) begin
            if (rst)
                mem_r[i] <= `SLCD_RST_BYTE;
            else if (mem_clear)
                mem_r[i] <= `SLCD_RST_BYTE;
            else if (hit)
                mem_r[i] <= dat_r;
        end
        // Shadow lets software rewrite many bytes without tearing
        always_ff @(posedge clk or posedge rst) begin
            if (rst)
                shadow_r[i] <= `SLCD_RST_BYTE;
            else if (!freeze)
                shadow_r[i] <= mem_r[i];
        end
    end

    // ************************************************************
    // Waveform timing
    // ************************************************************
    logic tick_fast, tick_slow;

    slcd_ticks #(
        .FAST_DIV(FAST_DIV),
        .SLOW_DIV(SLOW_DIV)
    ) u_ticks (
        .clk(clk),
        .rst(rst),
        .tick_fast(tick_fast),
        .tick_slow(tick_slow)
    );

    wire fast_sel = con_r[`SLCD_CON_LCD_CLOCK_SELECT];
    wire base_tick = fast_sel ? tick_fast : tick_slow;
    wire [3:0] frame_divider = clk_ctl_r[3:0];
    wire slcd_pkg::slcd_mux_t multiplex_select =
        slcd_pkg::slcd_mux_t'(con_r[1:0]);
    wire mux_ge3 = multiplex_select[1];
    wire [1:0] com_last = (multiplex_select == slcd_pkg::SLCD_MUX_FOUR)
        ? 2'h3 : (mux_ge3 ? 2'h2 : 2'h1);

    // Base ticks per half step of the common line
    function automatic logic [6:0] half_len(
        input logic fast,
        input logic [3:0] fd,
        input logic wide
    );
        if (fast)
            half_len = 7'({3'h0, fd} + 7'h01) << 2;
        else if (fd == 4'hf)
            half_len = `SLCD_STEP_FD15;
        else if (fd == 4'h0)
            half_len = `SLCD_STEP_FD0;
        else if (wide || fd == 4'h1)
            half_len = `SLCD_STEP_FD1;
        else if (fd == 4'h2)
            half_len = `SLCD_STEP_FD2;
        else
            half_len = `SLCD_STEP_SLOW;
    endfunction

    wire [6:0] half_top = half_len(fast_sel, frame_divider, mux_ge3);
    logic [6:0] half_cnt_r;
    logic phase_r, pol_r;
    logic [1:0] com_idx_r;
    wire half_tick = base_tick & (half_cnt_r >= half_top - 7'h01);

    // Half step counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            half_cnt_r <= 7'h00;
        else if (half_tick)
            half_cnt_r <= 7'h00;
        else if (base_tick)
            half_cnt_r <= half_cnt_r + 7'h01;
    end

    // Polarity flips each half step, so each common step is DC free
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pol_r <= 1'b0;
            phase_r <= 1'b0;
            com_idx_r <= 2'h0;
        end else if (half_tick) begin
            pol_r <= ~pol_r;
            phase_r <= ~phase_r;
            if (phase_r)
                com_idx_r <= (com_idx_r >= com_last) ? 2'h0
                    : com_idx_r + 2'h1;
        end
    end

    // ************************************************************
    // Blink
    // ************************************************************
    wire [1:0] blink_mode_bits = clk_ctl_r[7:6];
    wire [1:0] blink_frequency_bits = clk_ctl_r[5:4];
    wire blink_enable = con_r[`SLCD_CON_BLINK];
    wire auto_blink = blink_mode_bits[1];
    wire [2:0] rate_raw = {blink_mode_bits[0], blink_frequency_bits};
    wire [2:0] rate_idx = (rate_raw > `SLCD_BLINK_TOP)
        ? `SLCD_BLINK_TOP : rate_raw;
    wire [10:0] blink_top = `SLCD_BLINK_BASE << rate_idx;
    logic [10:0] blink_cnt_r;
    logic auto_on_r;
    wire blink_run = blink_enable & auto_blink & rtc_enable;
    wire blink_wrap = blink_run & tick_slow
        & (blink_cnt_r >= blink_top - 11'h001);

    // Automatic blink counter runs from the slow base clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blink_cnt_r <= 11'h000;
            auto_on_r <= 1'b1;
        end else if (!blink_run) begin
            blink_cnt_r <= 11'h000;
            auto_on_r <= 1'b1;
        end else if (blink_wrap) begin
            blink_cnt_r <= 11'h000;
            auto_on_r <= ~auto_on_r;
        end else if (tick_slow) begin
            blink_cnt_r <= blink_cnt_r + 11'h001;
        end
    end

    // Without the RTC automatic mode shows a steady image
    wire blink_on = auto_blink ? auto_on_r : blink_mode_bits[0];
    wire display_en = con_r[`SLCD_CON_EN]
        & ~(deep_power_save_mode & con_r[`SLCD_CON_PSM]);
    wire visible = display_en & (~blink_enable | blink_on);

    // ************************************************************
    // Pin drive
    // ************************************************************
    logic [3:0] com_nxt;
    logic [28:0] seg_nxt;

    // Common lines beyond com_last stay idle; static mode drives commons 0 and 1 like two way
    for (genvar k = 0; k < 4; k++) begin : g_com
        wire act = (com_idx_r == 2'(k)) & (2'(k) <= com_last);
        assign com_nxt[k] = visible & (act ^ pol_r);
    end

    // Even segment from low nibble, odd from high, column by common
    for (genvar s = 0; s < 29; s++) begin : g_seg
        wire on = shadow_r[s / 2][(s % 2) * 4 + com_idx_r];
        // Lit segment sits opposite the active common level
        assign seg_nxt[s] = visible & ~(on ^ pol_r);
    end

    // Pins 27 and 28 double as commons 3 and 2
    wire [28:0] pin_nxt = {
        mux_ge3 ? com_nxt[2] : seg_nxt[28],
        (multiplex_select == slcd_pkg::SLCD_MUX_FOUR)
            ? com_nxt[3] : seg_nxt[27],
        seg_nxt[26:0]
    };

    // Registered drive outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            common_line <= 4'h0;
            segment_line <= 29'h00000000;
            drive_polarity <= 1'b0;
            display_on <= 1'b0;
            pump_enable <= 1'b0;
        end else begin
            common_line <= com_nxt;
            segment_line <= pin_nxt;
            drive_polarity <= pol_r; // Stays aligned with the pins
            display_on <= visible;
            pump_enable <= display_en & ~conx_r[`SLCD_CONX_LADDER];
        end
    end

    // Straight register fields
    assign ladder_select = conx_r[`SLCD_CONX_LADDER];
    assign bias_level = conx_r[5:0];
    assign bias_third = con_r[`SLCD_CON_BIAS];

    // ************************************************************
    // Checks
    // ************************************************************
    wire mem_any = |{mem_r[0], mem_r[1], mem_r[2], mem_r[3], mem_r[4],
        mem_r[5], mem_r[6], mem_r[7], mem_r[8], mem_r[9], mem_r[10],
        mem_r[11], mem_r[12], mem_r[13], mem_r[14]};
    wire [119:0] shadow_flat = {>>{shadow_r}};
    wire [119:0] mem_flat = {>>{mem_r}};

    property p_ptr_write;
        @(posedge clk) disable iff (rst)
        ptr_wr_hit |=> mem_at_ptr == $past(dat_r);
    endproperty
    a_ptr_write: assert property (p_ptr_write)
        else $error("pointer write did not store data");

    property p_ptr_read;
        @(posedge clk) disable iff (rst)
        ptr_rd |=> dat_r == $past(mem_at_wr);
    endproperty
    a_ptr_read: assert property (p_ptr_read)
        else $error("pointer read did not load data");

    property p_range;
        @(posedge clk) disable iff (rst)
        ptr_rd && !idx_ok |=> dat_r == `SLCD_RST_BYTE;
    endproperty
    a_range: assert property (p_range)
        else $error("out of range read not zero");

    property p_clear;
        @(posedge clk) disable iff (rst)
        mem_clear |=> !mem_any;
    endproperty
    a_clear: assert property (p_clear)
        else $error("memory clear left data");

    property p_freeze;
        @(posedge clk) disable iff (rst)
        freeze |=> shadow_flat == $past(shadow_flat);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("shown image changed while frozen");

    property p_unfreeze;
        @(posedge clk) disable iff (rst)
        !freeze |=> shadow_flat == $past(mem_flat);
    endproperty
    a_unfreeze: assert property (p_unfreeze)
        else $error("shadow not refreshed");

    property p_polarity;
        @(posedge clk) disable iff (rst)
        half_tick |=> ##1 drive_polarity != $past(drive_polarity);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity did not invert");

    property p_pump;
        @(posedge clk) disable iff (rst)
        !display_en && !ladder_select |=> !pump_enable;
    endproperty
    a_pump: assert property (p_pump)
        else $error("pump on with display disabled");

    property p_soft_blink;
        @(posedge clk) disable iff (rst)
        blink_enable && blink_mode_bits == 2'h0 |=> !display_on;
    endproperty
    a_soft_blink: assert property (p_soft_blink)
        else $error("software blink off not honoured");

    property p_mux_three;
        @(posedge clk) disable iff (rst)
        multiplex_select == slcd_pkg::SLCD_MUX_THREE
            && com_idx_r != 2'h3 |=> com_idx_r != 2'h3;
    endproperty
    a_mux_three: assert property (p_mux_three)
        else $error("fourth common used in three way mode");
endmodule

// >>> verif/slcd_glass.sv
// Passive model of the segment glass, recording lit segments
`timescale 1ns/1ps
module slcd_glass (
    input wire logic clk,               // System clock
    input wire logic [3:0] common_line, // Common levels
    input wire logic [28:0] segment_line, // Segment pin levels
    input wire logic drive_polarity,    // Inversion phase
    input wire logic display_on,        // Display visible
    output logic [28:0][3:0] image      // Lit state, segment by common
);
    // ****************************
    // Lit state capture
    // ****************************
    // A segment is lit when its pin opposes the active common; a blank
    // period keeps the last image so a frozen display can be compared
    initial image = '0;
    always @(posedge clk) begin
        if (display_on) begin
            for (int k = 0; k < 4; k++) begin
                if (common_line[k] !== drive_polarity) begin
                    for (int s = 0; s < 29; s++) begin
                        image[s][k] <= segment_line[s] ^ common_line[k];
                    end
                end
            end
        end
    end
endmodule

// >>> verif/slcd_tb.sv
// Self-checking bench for the segment LCD controller
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} slcd_row_t;
    logic clk, rst, sfr_wr, sfr_rd, rtc_enable, deep_power_save_mode;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
    logic [3:0] common_line;
    logic [28:0] segment_line;
    logic drive_polarity, display_on, pump_enable, ladder_select, bias_third;
    logic [5:0] bias_level;
    logic [28:0][3:0] image;
    int miscompares = 0;
    int n_compared = 0;
    int n, a, m;
    // Register rows: address, value written, value read back
    slcd_row_t rows [9] = '{'{8'h95, 8'h4f, 8'h0f}, '{8'h96, 8'ha5, 8'ha5},
        '{8'h9c, 8'h3f, 8'h3f}, '{8'hac, 8'h45, 8'h05},
        '{8'hae, 8'hc3, 8'hc3}, '{8'hb1, 8'h01, 8'h01},
        '{8'h97, 8'hff, 8'h00}, '{8'hb1, 8'h00, 8'h00},
        '{8'h9c, 8'h6e, 8'h6e}};
    // Timing rows: configuration, divider, clocks per half step
    logic [7:0] tcon [10] = '{8'h8b, 8'h8b, 8'h89, 8'h88, 8'h83, 8'h83,
        8'h83, 8'h81, 8'h82, 8'h81};
    logic [7:0] tfd [10] = '{8'h00, 8'h0f, 8'h03, 8'h01, 8'h0f, 8'h00,
        8'h01, 8'h02, 8'h05, 8'h09};
    int tgap [10] = '{8, 128, 32, 16, 4, 8, 16, 24, 16, 32};

    // Short dividers keep frames to a few hundred clocks
    slcd_ctrl #(.FAST_DIV(2), .SLOW_DIV(4)) DUT (.clk(clk), .rst(rst),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .rtc_enable(rtc_enable),
        .deep_power_save_mode(deep_power_save_mode),
        .common_line(common_line), .segment_line(segment_line),
        .drive_polarity(drive_polarity), .display_on(display_on),
        .pump_enable(pump_enable), .ladder_select(ladder_select),
        .bias_level(bias_level), .bias_third(bias_third));
    slcd_glass panel (.clk(clk), .common_line(common_line),
        .segment_line(segment_line), .drive_polarity(drive_polarity),
        .display_on(display_on), .image(image));

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // ****************************
    // Helpers
    // ****************************
    task chk(input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        sfr_addr <= ad;
        sfr_wdata <= dt;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    // Read data is sampled at the falling edge, well after it settles
    task rd(input logic [7:0] ad, output logic [7:0] dt);
        @(posedge clk);
        sfr_addr <= ad;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(negedge clk);
        dt = sfr_rdata;
    endtask
    task wmem(input int i, input logic [7:0] dt);
        wr(8'hae, dt);
        wr(8'hac, 8'h80 | 8'(i));
    endtask
    task rmem(input int i, output logic [7:0] dt);
        wr(8'hac, 8'(i));
        rd(8'hae, dt);
    endtask
    task idle(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask
    function logic [7:0] pat(input int i);
        return 8'(i * 37) ^ 8'h5a;
    endfunction
    function int act();
        for (int k = 0; k < 4; k++) begin
            if (common_line[k] !== drive_polarity) return k;
        end
        return 7;
    endfunction
    function int val(input int w);
        return w == 0 ? int'(drive_polarity) : w == 1 ? int'(display_on) : act();
    endfunction
    // Skips the first partial interval, then times one full interval
    task gap(input int w, output int c);
        int v;
        @(negedge clk);
        for (int j = 0; j < 2; j++) begin
            v = val(w);
            c = 0;
            while (val(w) == v && c < 5000) begin
                @(negedge clk);
                c++;
            end
        end
    endtask
    task stop_test();
        $display("Compared %0d values, %0d wrong", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    // ****************************
    // Main sequence
    // ****************************
    initial begin
        clk = 0;
        rst = 1;
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = '0;
        rtc_enable = 0;
        deep_power_save_mode = 0;
        repeat (6) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        chk(display_on, 0);
        chk(pump_enable, 0);
        foreach (rows[i]) begin
            rd(rows[i].a, d);
            chk(d, 0);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            chk(d, rows[i].r);
        end
        chk({ladder_select, bias_level, bias_third}, 8'hdd);
        wr(8'h9c, 8'h00);
        // Waveform timing per clock, multiplex and divider setting
        for (int i = 0; i < 10; i++) begin
            wr(8'h96, tfd[i]);
            wr(8'h95, tcon[i]);
            gap(0, n);
            chk(n, tgap[i]);
            m = (tcon[i][1:0] < 2) ? 2 : tcon[i][1:0] + 1;
            gap(2, n);
            chk(n, 2 * tgap[i]);
            a = act();
            gap(2, n);
            chk(act(), (a + 2) % m);
            if (tcon[i][1]) chk(segment_line[28], common_line[2]);
            if (tcon[i][1:0] == 3) chk(segment_line[27], common_line[3]);
            chk(pump_enable, 1);
        end
        // Frozen update, then release and compare the glass image
        wr(8'h96, 8'h00);
        wr(8'h95, 8'h8b);
        wr(8'hb1, 8'h01);
        for (int i = 0; i < 15; i++) wmem(i, pat(i));
        idle(200);
        chk(image[26:0], 0);
        wr(8'hb1, 8'h00);
        idle(200);
        for (int s = 0; s < 27; s++) begin
            d = pat(s / 2);
            chk(image[s], s % 2 ? d[7:4] : d[3:0]);
        end
        for (int i = 0; i < 15; i++) begin
            rmem(i, d);
            chk(d, pat(i));
        end
        wmem(15, 8'hff);
        rmem(15, d);
        chk(d, 0);
        rmem(14, d);
        chk(d, pat(14));
        // Software blink follows the mode bits; automatic needs the clock
        wr(8'h95, 8'hab);
        idle(2);
        chk(display_on, 0);
        wr(8'h96, 8'h40);
        idle(2);
        chk(display_on, 1);
        wr(8'h96, 8'h80);
        idle(600);
        chk(display_on, 1);
        @(posedge clk);
        rtc_enable <= 1;
        for (int i = 0; i < 6; i++) begin
            m = i == 5 ? 7 : i;
            wr(8'h96, {1'b1, 3'(m), 4'h0});
            gap(1, n);
            chk(n, (64 << (m > 4 ? 4 : m)) * 4);
        end
        @(posedge clk);
        rtc_enable <= 0;
        // Deep power save blanks the display and keeps the memory
        wr(8'h96, 8'h00);
        wr(8'h95, 8'h9b);
        idle(2);
        chk({display_on, pump_enable}, 2'h3);
        @(posedge clk);
        deep_power_save_mode <= 1;
        idle(2);
        chk({display_on, pump_enable, common_line}, 0);
        rmem(3, d);
        chk(d, pat(3));
        @(posedge clk);
        deep_power_save_mode <= 0;
        wr(8'h9c, 8'h40);
        idle(2);
        chk({ladder_select, pump_enable}, 2'h2);
        // Memory clear bit, then a reset in mid-run
        wr(8'h95, 8'hcb);
        rmem(5, d);
        chk(d, 0);
        rd(8'h95, d);
        chk(d, 8'h8b);
        wmem(2, 8'h77);
        @(posedge clk);
        rst <= 1;
        idle(2);
        chk({display_on, common_line, segment_line}, 0);
        @(posedge clk);
        rst <= 0;
        rmem(2, d);
        chk(d, 0);
        stop_test();
    end
endmodule
